// [common/dio_map.svh]
// register map, field positions and reset values for the digital i/o port
//------------------------------------------------------------------------
//------------------------------------------------------------------------
`ifndef DIO_MAP_SVH
`define DIO_MAP_SVH
`define DIO_ADDR_OUT 4'h0
`define DIO_ADDR_DIR 4'h1
`define DIO_ADDR_PIN 4'h2
`define DIO_ADDR_MASK 4'h3
`define DIO_ADDR_CTRL 4'h4
`define DIO_ADDR_STAT 4'h5
`define DIO_ADDR_IEN 4'h6
`define DIO_CTRL_PUD 0
`define DIO_CTRL_GEN 1
`define DIO_STAT_PC 0
`define DIO_RST_BYTE 8'h00
`define DIO_RESP_OKAY 2'b00
`define DIO_RESP_SLVERR 2'b10
`endif

// [common/dio_pin_if.sv]
// per-port pin control bundle between the register file and the pad logic
`timescale 1ns/10ps
interface dio_pin_if #(parameter int WIDTH = 8);
    logic [WIDTH-1:0] out_bits;
    logic [WIDTH-1:0] dir_bits;
    logic pullup_global_disable;
    logic [WIDTH-1:0] in_bits;
    modport ctrl (output out_bits, output dir_bits, output pullup_global_disable, input in_bits);
    modport pad (input out_bits, input dir_bits, input pullup_global_disable, output in_bits);
endinterface : dio_pin_if

// [common/dio_pkg.sv]
// types shared by the digital i/o port modules
package dio_pkg;
    typedef enum logic [1:0] {
        DIO_IDLE = 2'b00,
        DIO_RESP = 2'b01
    } dio_bus_state_type;
endpackage : dio_pkg

// [dv/dio_pin_model.sv]
// outside circuitry on the port pins
`timescale 1ns/10ps
module dio_pin_model #(
    parameter int WIDTH = 8
) (
    input wire logic aclk, // clock
    input wire logic [WIDTH-1:0] pin_o, // device drive value
    input wire logic [WIDTH-1:0] pin_oe, // device drive enable
    input wire logic [WIDTH-1:0] pin_pu, // device pull-up
    input wire logic [WIDTH-1:0] ext_en, // outside driver enable
    input wire logic [WIDTH-1:0] ext_val, // outside driver value
    output logic [WIDTH-1:0] pin_i // resolved pad level
);
    // a floating pin wanders every cycle so no test can lean on a stale level
    logic [WIDTH-1:0] float_q = '0;
    always @(posedge aclk) begin
        float_q <= ~pin_i;
    end
    assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_en & ext_val)
        | (~pin_oe & ~ext_en & (pin_pu | float_q));
endmodule : dio_pin_model

// [dv/dio_port_chk.sv]
// concurrent checks on the digital i/o port top-level ports
`timescale 1ns/10ps
module dio_port_chk #(
    parameter int WIDTH = 8
) (
    input wire logic aclk, // clock
    input wire logic aresetn, // reset, low active
    input wire logic awvalid, // aw valid
    input wire logic awready, // aw ready
    input wire logic wvalid, // w valid
    input wire logic wready, // w ready
    input wire logic bvalid, // b valid
    input wire logic bready, // b ready
    input wire logic arvalid, // ar valid
    input wire logic arready, // ar ready
    input wire logic rvalid, // r valid
    input wire logic rready, // r ready
    input wire logic [WIDTH-1:0] pin_o, // drive values
    input wire logic [WIDTH-1:0] pin_oe, // drive enables
    input wire logic [WIDTH-1:0] pin_pu, // pull-ups
    input wire logic irq // interrupt
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    //----
    // properties
    //----
    // reset check must run while reset is low, so it overrides the default
    property p_rst_hiz;
        disable iff (1'b0) !aresetn |-> pin_oe == '0 && pin_pu == '0;
    endproperty
    property p_pu_oe;
        (pin_pu & pin_oe) == '0;
    endproperty
    // both halves taken at one edge; the register lands one edge later with bvalid
    property p_wr_resp;
        awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid;
    endproperty
    property p_b_done;
        bvalid && bready |=> !bvalid && awready;
    endproperty
    property p_rd_resp;
        arvalid && arready |=> rvalid && !arready;
    endproperty
    property p_r_done;
        rvalid && rready |=> !rvalid;
    endproperty
    property p_out_wr;
        !$stable(pin_o) |-> $rose(bvalid);
    endproperty
    property p_oe_wr;
        !$stable(pin_oe) |-> $rose(bvalid);
    endproperty
    property p_pu_wr;
        !$stable(pin_pu) |-> $rose(bvalid);
    endproperty
    property p_irq_fall;
        $fell(irq) |-> $rose(bvalid);
    endproperty
    a_rst_hiz: assert property (p_rst_hiz) else $error("pins driven in reset");
    a_pu_oe: assert property (p_pu_oe) else $error("pull-up on driven pin");
    a_wr_resp: assert property (p_wr_resp) else $error("late write response");
    a_b_done: assert property (p_b_done) else $error("write response stuck");
    a_rd_resp: assert property (p_rd_resp) else $error("late read data");
    a_r_done: assert property (p_r_done) else $error("read data stuck");
    a_out_wr: assert property (p_out_wr) else $error("drive moved alone");
    a_oe_wr: assert property (p_oe_wr) else $error("direction moved alone");
    a_pu_wr: assert property (p_pu_wr) else $error("pull-up moved alone");
    a_irq_fall: assert property (p_irq_fall) else $error("irq dropped alone");
    c_wr: cover property (bvalid && bready);
    c_rd: cover property (rvalid && rready);
    c_irq: cover property ($rose(irq));
endmodule : dio_port_chk

bind dio_port dio_port_chk #(.WIDTH(WIDTH)) u_chk (.aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
    .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready),
    .rvalid(rvalid), .rready(rready), .pin_o(pin_o), .pin_oe(pin_oe),
    .pin_pu(pin_pu), .irq(irq));

// [dv/test_digital_io_port.sv]
// self-checking bench for the digital i/o port
`timescale 1ns/10ps
`include "dio_map.svh"
module test_digital_io_port;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
    logic [1:0] bresp, rresp, rsp;
    logic [3:0] wstrb = 4'hf;
    logic [7:0] pin_i, pin_o, pin_oe, pin_pu, ext_en = '0, ext_val = '0;
    int errors = 0, check_count = 0, cycles = 0;
    always #4 aclk = ~aclk;
    dio_port #(.WIDTH(8)) u_dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready),
        .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .pin_i(pin_i),
        .pin_o(pin_o), .pin_oe(pin_oe), .pin_pu(pin_pu), .irq(irq));
    dio_pin_model #(.WIDTH(8)) u_pins (.aclk(aclk), .pin_o(pin_o), .pin_oe(pin_oe),
        .pin_pu(pin_pu), .ext_en(ext_en), .ext_val(ext_val), .pin_i(pin_i));
    //----
    // bus and compare tasks
    //----
    function automatic logic [31:0] adr(input logic [3:0] idx);
        return {26'h000_0000, idx, 2'b00};
    endfunction : adr
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        logic aw_ok;
        logic w_ok;
        @(posedge aclk);
        aw_ok = 1'b0;
        w_ok = 1'b0;
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= {24'h00_0000, d};
        bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (!aw_ok && awready) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!bvalid);
        bready <= 1'b0;
        rsp = bresp;
    endtask : wr
    task automatic rd_chk(input logic [31:0] a, input logic [7:0] exp);
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        rready <= 1'b0;
        rsp = rresp;
        check("read data", rdata, {24'h00_0000, exp});
    endtask : rd_chk
    //----
    // scenarios
    //----
    task automatic t_reset_vals();
        for (int i = 0; i < 7; i++)
            if (i != 2) rd_chk(adr(4'(i)), 8'h00);
        check("oe", 32'(pin_oe), 32'h0000_0000);
        rd_chk(adr(4'hf), 8'h00);
        check("resp", 32'(rsp), 32'(`DIO_RESP_SLVERR));
        $display("reset values done");
    endtask : t_reset_vals
    task automatic t_pins();
        ext_en <= 8'hf0;
        ext_val <= 8'h50;
        wr(adr(`DIO_ADDR_OUT), 8'ha5); // data before direction
        wr(adr(`DIO_ADDR_DIR), 8'h0f);
        rd_chk(adr(`DIO_ADDR_OUT), 8'ha5);
        rd_chk(adr(`DIO_ADDR_DIR), 8'h0f);
        check("rd resp", 32'(rsp), 32'(`DIO_RESP_OKAY));
        check("oe", 32'(pin_oe), 32'h0000_000f);
        check("drive", 32'(pin_o & pin_oe), 32'h0000_0005);
        check("pu", 32'(pin_pu), 32'h0000_00a0);
        wr(adr(`DIO_ADDR_CTRL), 8'h01);
        check("pu off", 32'(pin_pu), 32'h0000_0000);
        wr(adr(`DIO_ADDR_CTRL), 8'h00);
        wr(adr(`DIO_ADDR_PIN), 8'h81);
        rd_chk(adr(`DIO_ADDR_OUT), 8'h24);
        rd_chk(adr(`DIO_ADDR_DIR), 8'h0f);
        check("pu one", 32'(pin_pu), 32'h0000_0020);
        wr(adr(`DIO_ADDR_PIN), 8'h00);
        rd_chk(adr(`DIO_ADDR_PIN), 8'h54);
        rd_chk(adr(`DIO_ADDR_OUT), 8'h24);
        ext_val <= 8'ha0;
        // read goes out at once, so a deeper synchroniser would show the old level
        rd_chk(adr(`DIO_ADDR_PIN), 8'ha4);
        wr(adr(4'hf), 8'h01);
        check("wr resp", 32'(rsp), 32'(`DIO_RESP_SLVERR));
        // a write without lane 0 is answered but leaves the port alone
        wstrb <= 4'he;
        wr(adr(`DIO_ADDR_OUT), 8'hff);
        wstrb <= 4'hf;
        check("wr resp", 32'(rsp), 32'(`DIO_RESP_OKAY));
        rd_chk(adr(`DIO_ADDR_OUT), 8'h24);
        $display("pin control done");
    endtask : t_pins
    task automatic t_irq();
        ext_en <= 8'hff;
        ext_val <= 8'h00;
        wr(adr(`DIO_ADDR_DIR), 8'h00);
        wr(adr(`DIO_ADDR_MASK), 8'h01);
        wr(adr(`DIO_ADDR_IEN), 8'h01);
        ext_val <= 8'h01;
        repeat (4) @(posedge aclk);
        rd_chk(adr(`DIO_ADDR_STAT), 8'h00);
        wr(adr(`DIO_ADDR_CTRL), 8'h02);
        ext_val <= 8'h03;
        repeat (4) @(posedge aclk);
        rd_chk(adr(`DIO_ADDR_STAT), 8'h00);
        ext_val <= 8'h02;
        repeat (4) @(posedge aclk);
        rd_chk(adr(`DIO_ADDR_STAT), 8'h01);
        check("irq set", 32'(irq), 32'h0000_0001);
        wr(adr(`DIO_ADDR_IEN), 8'h00);
        check("irq masked", 32'(irq), 32'h0000_0000);
        wr(adr(`DIO_ADDR_IEN), 8'h01);
        wr(adr(`DIO_ADDR_STAT), 8'h01);
        rd_chk(adr(`DIO_ADDR_STAT), 8'h00);
        check("irq clear", 32'(irq), 32'h0000_0000);
        $display("pin change done");
    endtask : t_irq
    task automatic t_mid_reset();
        wr(adr(`DIO_ADDR_DIR), 8'h24);
        check("oe", 32'(pin_oe), 32'h0000_0024);
        aresetn <= 1'b0;
        #1;
        check("oe rst", 32'(pin_oe | pin_pu), 32'h0000_0000);
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(adr(`DIO_ADDR_DIR), 8'h00);
        $display("mid-run reset done");
    endtask : t_mid_reset
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : summarize
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            summarize();
        end
    end
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset_vals();
        t_pins();
        t_irq();
        t_mid_reset();
        summarize();
    end
endmodule : test_digital_io_port

// [hw/dio_pad.sv]
// pad drive, pull-up and input synchroniser for every pin
`timescale 1ns/10ps
`include "dio_map.svh"
module dio_pad #(
    parameter int WIDTH = 8
) (
    input wire logic aclk,              // clock
    input wire logic aresetn,           // reset, low active
    dio_pin_if.pad pins,                // control from registers
    input wire logic [WIDTH-1:0] pin_i, // pad level
    output logic [WIDTH-1:0] pin_o,     // pad drive value
    output logic [WIDTH-1:0] pin_oe,    // pad drive enable
    output logic [WIDTH-1:0] pin_pu     // pad pull-up enable
);
    typedef struct packed {
        logic [WIDTH-1:0] sync;
    } dio_pad_st_type;
    dio_pad_st_type st_q, st_d;
    logic [WIDTH-1:0] latch_q;

    // falling-edge stage stands in for the clock-high transparent latch
    always_ff @(negedge aclk) begin
        latch_q <= pin_i;
    end

    always_comb begin
        st_d = st_q;
        st_d.sync = latch_q;
        if (!aresetn) begin
            st_d.sync = '0;
        end
    end

    always_ff @(posedge aclk) begin
        st_q <= st_d;
    end
    assign pins.in_bits = st_q.sync;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_pin
            // reset gates drive and pull-up directly, no clock needed
            assign pin_oe[i] = aresetn & pins.dir_bits[i];
            assign pin_o[i] = pins.out_bits[i];
            assign pin_pu[i] = aresetn & ~pins.dir_bits[i] & pins.out_bits[i]
                & ~pins.pullup_global_disable;
        end
    endgenerate
endmodule : dio_pad

// [hw/dio_pc_detect.sv]
// pin-change detector on the synchronised inputs
`timescale 1ns/10ps
`include "dio_map.svh"
module dio_pc_detect #(
    parameter int WIDTH = 8
) (
    input wire logic aclk,              // clock
    input wire logic aresetn,           // reset, low active
    input wire logic [WIDTH-1:0] in_bits, // synchronised pins
    input wire logic [WIDTH-1:0] mask,  // per-pin enable
    input wire logic group_en,          // group enable
    output logic change                 // one-cycle change pulse
);
    typedef struct packed {
        logic [WIDTH-1:0] prev;
        logic primed;
    } dio_pc_st_type;
    dio_pc_st_type st_q, st_d;

    always_comb begin
        st_d.prev = in_bits;
        st_d.primed = 1'b1;
        if (!aresetn) begin
            st_d.prev = '0;
            st_d.primed = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        st_q <= st_d;
    end

    // primed only masks the cycle before the first edge out of reset; the first sample is still compared with the cleared prev
    assign change = st_q.primed & group_en
        & (|((in_bits ^ st_q.prev) & mask));
endmodule : dio_pc_detect

// [hw/dio_port.sv]
// digital i/o port with axi4-lite register access and pin-change interrupt
//
// The AXI4-Lite register port and the register addresses were decided locally.
`timescale 1ns/10ps
`include "dio_map.svh"
module dio_port #(
    parameter int WIDTH = 8
) (
    input wire logic aclk,                 // clock, 125 MHz
    input wire logic aresetn,              // reset, low active; synchronous for the registers, but pin_oe and pin_pu clear at once without a clock
    input wire logic awvalid,              // write address valid
    output logic awready,                  // write address ready
    input wire logic [31:0] awaddr,        // write address
    input wire logic [2:0] awprot,         // write protection, unused
    input wire logic wvalid,               // write data valid
    output logic wready,                   // write data ready
    input wire logic [31:0] wdata,         // write data
    input wire logic [3:0] wstrb,          // write byte strobes
    output logic bvalid,                   // write response valid
    input wire logic bready,               // write response ready
    output logic [1:0] bresp,              // write response
    input wire logic arvalid,              // read address valid
    output logic arready,                  // read address ready
    input wire logic [31:0] araddr,        // read address
    input wire logic [2:0] arprot,         // read protection, unused
    output logic rvalid,                   // read data valid
    input wire logic rready,               // read data ready
    output logic [31:0] rdata,             // read data
    output logic [1:0] rresp,              // read response
    input wire logic [WIDTH-1:0] pin_i,    // pad levels
    output logic [WIDTH-1:0] pin_o,        // pad drive values
    output logic [WIDTH-1:0] pin_oe,       // pad drive enables
    output logic [WIDTH-1:0] pin_pu,       // pad pull-up enables
    output logic irq                       // level interrupt
);
    //--------------------------------------------------------------------
    // parameter check
    //--------------------------------------------------------------------
    generate
        if (WIDTH < 1 || WIDTH > 32) begin : g_bad_width
            $error("dio_port: WIDTH must be 1 to 32");
        end
    endgenerate

    //--------------------------------------------------------------------
    // state
    //--------------------------------------------------------------------
    typedef struct packed {
        logic [WIDTH-1:0] out_bits;
        logic [WIDTH-1:0] dir_bits;
        logic [WIDTH-1:0] mask;
        logic pullup_global_disable;
        logic group_en;
        logic pc_flag;
        logic pc_ien;
        logic aw_got;
        logic [3:0] aw_idx;
        logic aw_ok;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        dio_pkg::dio_bus_state_type wr_st;
        logic [1:0] b_resp;
        dio_pkg::dio_bus_state_type rd_st;
        logic [31:0] r_data;
        logic [1:0] r_resp;
    } dio_port_st_type;
    dio_port_st_type st_q, st_d;

    dio_pin_if #(.WIDTH(WIDTH)) pins ();
    logic pc_change;
    logic wr_go;
    logic [WIDTH-1:0] wr_byte;

    assign pins.out_bits = st_q.out_bits;
    assign pins.dir_bits = st_q.dir_bits;
    assign pins.pullup_global_disable = st_q.pullup_global_disable;

    dio_pad #(.WIDTH(WIDTH)) u_pad (
        .aclk(aclk),
        .aresetn(aresetn),
        .pins(pins.pad),
        .pin_i(pin_i),
        .pin_o(pin_o),
        .pin_oe(pin_oe),
        .pin_pu(pin_pu)
    );

    dio_pc_detect #(.WIDTH(WIDTH)) u_pc (
        .aclk(aclk),
        .aresetn(aresetn),
        .in_bits(pins.in_bits),
        .mask(st_q.mask),
        .group_en(st_q.group_en),
        .change(pc_change)
    );

    //--------------------------------------------------------------------
    // bus handshakes
    //--------------------------------------------------------------------
    // address and data are held separately so either may come first
    assign awready = (st_q.wr_st == dio_pkg::DIO_IDLE) & ~st_q.aw_got;
    assign wready = (st_q.wr_st == dio_pkg::DIO_IDLE) & ~st_q.w_got;
    assign bvalid = (st_q.wr_st == dio_pkg::DIO_RESP);
    assign bresp = st_q.b_resp;
    assign arready = (st_q.rd_st == dio_pkg::DIO_IDLE);
    assign rvalid = (st_q.rd_st == dio_pkg::DIO_RESP);
    assign rdata = st_q.r_data;
    assign rresp = st_q.r_resp;
    assign irq = st_q.pc_flag & st_q.pc_ien;

    // a write takes effect on the edge after both halves are held
    assign wr_go = (st_q.wr_st == dio_pkg::DIO_IDLE) & st_q.aw_got & st_q.w_got;
    // only the lane 0 strobe gates the write; a port wider than 8 bits takes its upper bits from lanes 1 to 3 too
    assign wr_byte = st_q.w_strb[0] ? st_q.w_data[WIDTH-1:0] : '0;

    function automatic logic addr_ok(input logic [31:0] a);
        addr_ok = (a[1:0] == 2'b00) && (a[31:6] == '0)
            && (a[5:2] <= `DIO_ADDR_IEN);
    endfunction : addr_ok

    //--------------------------------------------------------------------
    // next state
    //--------------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        // capture write halves
        if (awvalid && awready) begin
            st_d.aw_got = 1'b1;
            st_d.aw_idx = awaddr[5:2];
            st_d.aw_ok = addr_ok(awaddr);
        end
        if (wvalid && wready) begin
            st_d.w_got = 1'b1;
            st_d.w_data = wdata;
            st_d.w_strb = wstrb;
        end
        // status flag: a new change wins over a clear in the same cycle
        if (wr_go && st_q.aw_ok && st_q.aw_idx == `DIO_ADDR_STAT && st_q.w_strb[0]
            && st_q.w_data[`DIO_STAT_PC]) begin
            st_d.pc_flag = 1'b0;
        end
        if (pc_change) begin
            st_d.pc_flag = 1'b1;
        end
        // register write
        if (wr_go) begin
            st_d.aw_got = 1'b0;
            st_d.w_got = 1'b0;
            st_d.wr_st = dio_pkg::DIO_RESP;
            st_d.b_resp = st_q.aw_ok ? `DIO_RESP_OKAY : `DIO_RESP_SLVERR;
            if (st_q.aw_ok && st_q.w_strb[0]) begin
                case (st_q.aw_idx)
                    `DIO_ADDR_OUT: begin
                        st_d.out_bits = st_q.w_data[WIDTH-1:0];
                    end
                    `DIO_ADDR_DIR: begin
                        st_d.dir_bits = st_q.w_data[WIDTH-1:0];
                    end
                    `DIO_ADDR_PIN: begin
                        // only ones toggle; the input bits themselves are not stored
                        st_d.out_bits = st_q.out_bits ^ wr_byte;
                    end
                    `DIO_ADDR_MASK: begin
                        st_d.mask = st_q.w_data[WIDTH-1:0];
                    end
                    `DIO_ADDR_CTRL: begin
                        st_d.pullup_global_disable = st_q.w_data[`DIO_CTRL_PUD];
                        st_d.group_en = st_q.w_data[`DIO_CTRL_GEN];
                    end
                    `DIO_ADDR_IEN: begin
                        st_d.pc_ien = st_q.w_data[`DIO_STAT_PC];
                    end
                    default: begin
                    end
                endcase
            end
        end
        if (st_q.wr_st == dio_pkg::DIO_RESP && bready) begin
            st_d.wr_st = dio_pkg::DIO_IDLE;
        end
        // register read
        if (st_q.rd_st == dio_pkg::DIO_RESP && rready) begin
            st_d.rd_st = dio_pkg::DIO_IDLE;
        end
        if (arvalid && arready) begin
            st_d.rd_st = dio_pkg::DIO_RESP;
            st_d.r_data = '0;
            st_d.r_resp = addr_ok(araddr) ? `DIO_RESP_OKAY : `DIO_RESP_SLVERR;
            case (araddr[5:2])
                `DIO_ADDR_OUT: begin
                    st_d.r_data[WIDTH-1:0] = st_q.out_bits;
                end
                `DIO_ADDR_DIR: begin
                    st_d.r_data[WIDTH-1:0] = st_q.dir_bits;
                end
                `DIO_ADDR_PIN: begin
                    st_d.r_data[WIDTH-1:0] = pins.in_bits;
                end
                `DIO_ADDR_MASK: begin
                    st_d.r_data[WIDTH-1:0] = st_q.mask;
                end
                `DIO_ADDR_CTRL: begin
                    st_d.r_data[`DIO_CTRL_PUD] = st_q.pullup_global_disable;
                    st_d.r_data[`DIO_CTRL_GEN] = st_q.group_en;
                end
                `DIO_ADDR_STAT: begin
                    st_d.r_data[`DIO_STAT_PC] = st_q.pc_flag;
                end
                `DIO_ADDR_IEN: begin
                    st_d.r_data[`DIO_STAT_PC] = st_q.pc_ien;
                end
                default: begin
                end
            endcase
            if (!addr_ok(araddr)) begin
                st_d.r_data = '0;
            end
        end
        // reset
        if (!aresetn) begin
            st_d = '0;
            st_d.out_bits = WIDTH'(`DIO_RST_BYTE);
            st_d.dir_bits = WIDTH'(`DIO_RST_BYTE);
            st_d.mask = WIDTH'(`DIO_RST_BYTE);
            st_d.wr_st = dio_pkg::DIO_IDLE;
            st_d.rd_st = dio_pkg::DIO_IDLE;
        end
    end

    always_ff @(posedge aclk) begin
        st_q <= st_d;
    end
endmodule : dio_port
